// [core/pss_scan_seq.sv]
// scan-cycle sequencer: phase order, budgets, cycle statistics, watchdog
`timescale 1ns/1ns
module pss_scan_seq #(
    parameter int IMG_W = 16,
    parameter int CYC_US = pss_pkg::CYC_PER_US
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic larger_cpu,
    input wire logic clock_board,
    input wire logic periph_attached,
    input wire logic pc_link_en,
    input wire logic [1:0] link_sw,
    input wire logic [7:0] in_bytes,
    input wire logic [7:0] out_bytes,
    input wire logic [3:0] rio_masters,
    input wire logic [7:0] rio_words,
    input wire logic [3:0] hd_units,
    input wire pss_pkg::pss_us_t hd_refresh_us,
    input wire logic [3:0] host_units,
    input wire logic [3:0] net_units,
    input wire logic prog_done,
    input wire logic fixed_cycle_en,
    input wire pss_pkg::pss_us_t fixed_cycle_us,
    input wire pss_pkg::pss_us_t wd_limit_us,
    input wire logic watchdog_extend_instruction,
    input wire pss_pkg::pss_us_t wd_extend_us,
    input wire logic [IMG_W-1:0] in_pins,
    input wire logic [IMG_W-1:0] out_image,
    output pss_pkg::pss_state_e phase_q,
    output logic scanning_q,
    output logic [IMG_W-1:0] in_image_q,
    output logic [IMG_W-1:0] out_pins_q,
    output logic io_service_q,
    output logic host_service_q,
    output logic peri_service_q,
    output logic net_service_q,
    output logic prog_run_q,
    output logic wd_restart_q,
    output logic bus_check_q,
    output logic mem_check_q,
    output logic rtc_refresh_q,
    output pss_pkg::pss_word_t max_cycle_word_q,
    output pss_pkg::pss_word_t current_cycle_word_q,
    output pss_pkg::pss_us_t avg_cycle_us_q,
    output pss_pkg::pss_us_t max_cycle_us_q,
    output pss_pkg::pss_us_t min_cycle_us_q,
    output logic cycle_overrun_fatal_error_q,
    output logic [7:0] fatal_code_q
);
    import pss_pkg::*;

    pss_tmr_if tif ();

    pss_timer u_timer (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .t(tif.tmr)
    );

    logic [1:0] sw_s1_q, sw_s2_q;
    logic [IMG_W-1:0] pin_s1_q, pin_s2_q;
    logic [7:0] pre_q;
    pss_us_t now_q, cyc_start_q, ext_q, cur_us_q;
    pss_state_e state_q, state_d;
    logic start_q, stats_valid_q, scanned_q;

    // two-flop synchronisers for the switch and input pins
    always_ff @(posedge clk) begin
        if (reset) begin
            sw_s1_q <= '0;
            sw_s2_q <= '0;
            pin_s1_q <= '0;
            pin_s2_q <= '0;
        end else if (ce) begin
            sw_s1_q <= link_sw;
            sw_s2_q <= sw_s1_q;
            pin_s1_q <= in_pins;
            pin_s2_q <= pin_s1_q;
        end
    end

    // microsecond time base
    wire us_tick = (pre_q == 8'(CYC_US - 1));
    always_ff @(posedge clk) begin
        if (reset) begin
            pre_q <= '0;
            now_q <= '0;
        end else if (ce) begin
            pre_q <= us_tick ? 8'h00 : pre_q + 8'h01;
            now_q <= us_tick ? now_q + 24'h1 : now_q;
        end
    end

    // phase budgets
    wire pss_us_t link_us = (sw_s2_q == LINK_SW_512) ? LINK_512_US :
                            (sw_s2_q == LINK_SW_256) ? LINK_256_US :
                            (sw_s2_q == LINK_SW_128) ? LINK_128_US :
                            LINK_64_US;
    wire pss_us_t local_us = pss_us_t'(in_bytes) * IO_IN_BYTE_US
                           + pss_us_t'(out_bytes) * IO_OUT_BYTE_US;
    wire pss_us_t rio_us = pss_us_t'(rio_masters) * RIO_MASTER_US
                         + pss_us_t'(rio_words) * RIO_WORD_US;
    wire pss_us_t hd_us = (hd_units != 4'h0) ?
                          HD_INIT_US + hd_refresh_us : '0;
    wire pss_us_t io_us = local_us + rio_us + hd_us
                        + (pc_link_en ? link_us : '0);
    wire pss_us_t host_us = pss_us_t'(host_units) * HOST_UNIT_US;
    wire [31:0] peri_prod = 32'(cur_us_q) * PERI_PCT;
    wire pss_us_t peri_big = pss_us_t'(peri_prod / PCT_DIV);
    wire pss_us_t peri_us = !periph_attached ? '0 :
                            (cur_us_q <= PERI_LIMIT_US) ? PERI_SHORT_US :
                            peri_big;
    wire pss_us_t net_us = pss_us_t'(net_units) * NET_UNIT_US
                         + NET_MAX_US;
    wire pss_us_t ovsee_us = larger_cpu ? OVSEE_LARGE_US :
                             clock_board ? OVSEE_CLK_US :
                             OVSEE_NOCLK_US;
    wire pss_us_t phase_us = (state_q == ST_IOREF) ? io_us :
                             (state_q == ST_HOST) ? host_us :
                             (state_q == ST_PERI) ? peri_us :
                             (state_q == ST_NET) ? net_us :
                             (state_q == ST_OVSEE) ? ovsee_us : '0;

    assign tif.load = start_q;
    assign tif.value = phase_us;
    assign tif.tick = us_tick;

    // watchdog: cycle elapsed time against the set value plus extensions
    wire pss_us_t elapsed = now_q - cyc_start_q;
    wire pss_us_t wd_lim = wd_limit_us + ext_q;
    wire in_scan = (state_q != ST_HALT) && (state_q != ST_INIT0)
                && (state_q != ST_INIT1) && (state_q != ST_INIT2);
    wire overrun = in_scan && (elapsed > wd_lim
                || elapsed > ABS_LIMIT_US);
    wire fixed_ok = !fixed_cycle_en || elapsed >= fixed_cycle_us;
    wire phase_end = !start_q && tif.expired;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_INIT0: state_d = ST_INIT1;
            ST_INIT1: state_d = ST_INIT2;
            ST_INIT2: state_d = ST_IOREF;
            ST_IOREF: if (phase_end) state_d = ST_HOST;
            ST_HOST: if (phase_end) state_d = ST_PERI;
            ST_PERI: if (phase_end) begin
                state_d = larger_cpu ? ST_NET : ST_OVSEE;
            end
            ST_NET: if (phase_end) state_d = ST_OVSEE;
            ST_OVSEE: if (phase_end) state_d = ST_PROG;
            ST_PROG: if (!start_q && prog_done) state_d = ST_CALC;
            ST_CALC: if (!start_q && fixed_ok) state_d = ST_IOREF;
            ST_HALT: state_d = ST_HALT;
            default: state_d = ST_HALT;
        endcase
        if (overrun) begin
            state_d = ST_HALT;
        end
    end

    wire calc_done = (state_q == ST_CALC) && (state_d == ST_IOREF);
    wire boundary = calc_done
                 || (state_q == ST_INIT2 && state_d == ST_IOREF);
    wire enter_ovsee = (state_d == ST_OVSEE) && (state_q != ST_OVSEE);
    wire enter_io = (state_d == ST_IOREF) && (state_q != ST_IOREF);
    wire pss_us_t ext_base = boundary ? '0 : ext_q;
    wire pss_us_t cur_max = max_cycle_us_q;
    wire pss_us_t max_n = (!stats_valid_q || elapsed > cur_max) ?
                          elapsed : cur_max;
    wire pss_us_t min_n = (!stats_valid_q || elapsed < min_cycle_us_q) ?
                          elapsed : min_cycle_us_q;
    wire [31:0] avg_sum = 32'(avg_cycle_us_q) * AVG_KEEP + 32'(elapsed);
    wire pss_us_t avg_n = stats_valid_q ?
                          pss_us_t'(avg_sum >> AVG_SHIFT) : elapsed;

    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= ST_INIT0;
            start_q <= 1'b0;
            scanned_q <= 1'b0;
            cyc_start_q <= '0;
            ext_q <= '0;
        end else if (ce) begin
            state_q <= state_d;
            start_q <= (state_d != state_q);
            scanned_q <= scanned_q || (state_d == ST_IOREF);
            if (boundary) begin
                cyc_start_q <= now_q;
            end
            ext_q <= watchdog_extend_instruction ?
                     ext_base + wd_extend_us : ext_base;
        end
    end

    // cycle statistics, updated once per cycle at the calc boundary
    always_ff @(posedge clk) begin
        if (reset) begin
            stats_valid_q <= 1'b0;
            cur_us_q <= '0;
            avg_cycle_us_q <= '0;
            max_cycle_us_q <= '0;
            min_cycle_us_q <= '0;
            max_cycle_word_q <= '0;
            current_cycle_word_q <= '0;
        end else if (ce && calc_done) begin
            stats_valid_q <= 1'b1;
            cur_us_q <= elapsed;
            avg_cycle_us_q <= avg_n;
            max_cycle_us_q <= max_n;
            min_cycle_us_q <= min_n;
            max_cycle_word_q <= WORD_W'(max_n / US_PER_TENTH);
            current_cycle_word_q <= WORD_W'(elapsed / US_PER_TENTH);
        end
    end

    // phase outputs and io images
    always_ff @(posedge clk) begin
        if (reset) begin
            phase_q <= ST_INIT0;
            scanning_q <= 1'b0;
            in_image_q <= '0;
            out_pins_q <= '0;
            io_service_q <= 1'b0;
            host_service_q <= 1'b0;
            peri_service_q <= 1'b0;
            net_service_q <= 1'b0;
            prog_run_q <= 1'b0;
            wd_restart_q <= 1'b0;
            bus_check_q <= 1'b0;
            mem_check_q <= 1'b0;
            rtc_refresh_q <= 1'b0;
            cycle_overrun_fatal_error_q <= 1'b0;
            fatal_code_q <= '0;
        end else if (ce) begin
            phase_q <= state_d;
            scanning_q <= (state_d != ST_HALT) && scanned_q;
            if (enter_io) begin
                in_image_q <= pin_s2_q;
                out_pins_q <= out_image;
            end
            io_service_q <= (state_d == ST_IOREF);
            host_service_q <= (state_d == ST_HOST);
            peri_service_q <= (state_d == ST_PERI);
            net_service_q <= (state_d == ST_NET);
            prog_run_q <= (state_d == ST_PROG);
            wd_restart_q <= enter_ovsee
                         || (calc_done && fixed_cycle_en);
            bus_check_q <= enter_ovsee;
            mem_check_q <= enter_ovsee;
            rtc_refresh_q <= enter_ovsee;
            if (overrun) begin
                cycle_overrun_fatal_error_q <= 1'b1;
                fatal_code_q <= FATAL_CODE;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    chk_init_once: assert property (
        scanned_q |-> !(state_q inside {ST_INIT0, ST_INIT1, ST_INIT2}))
        else $error("power-up steps repeated after scanning began");
    chk_order_io_host: assert property (
        (ce && state_q == ST_IOREF && state_d != ST_IOREF && !overrun)
        |=> state_q == ST_HOST)
        else $error("io refresh not followed by host servicing");
    chk_order_ovsee_prog: assert property (
        (ce && state_q == ST_OVSEE && state_d != ST_OVSEE && !overrun)
        |=> state_q == ST_PROG && prog_run_q)
        else $error("oversee not followed by program execution");
    chk_net_skip: assert property (
        (ce && state_q == ST_PERI && state_d != ST_PERI && !overrun
         && !larger_cpu) |=> state_q == ST_OVSEE)
        else $error("network phase entered on small variant");
    chk_cycle_words: assert property (
        (ce && calc_done) |=> current_cycle_word_q
        == WORD_W'($past(elapsed) / US_PER_TENTH))
        else $error("current cycle word not refreshed");
    chk_stat_order: assert property (
        stats_valid_q |-> (min_cycle_us_q <= avg_cycle_us_q
        && avg_cycle_us_q <= max_cycle_us_q))
        else $error("cycle statistics out of order");
    chk_ovsee_work: assert property (
        (ce && enter_ovsee && !overrun) |=> wd_restart_q && bus_check_q
        && mem_check_q && rtc_refresh_q)
        else $error("oversee duties not strobed");
    chk_ovsee_len: assert property (
        (ce && start_q && state_q == ST_OVSEE && !larger_cpu
         && !clock_board) |-> tif.value == OVSEE_NOCLK_US)
        else $error("oversee budget wrong");
    chk_fixed_wait: assert property (
        (ce && calc_done && fixed_cycle_en)
        |-> elapsed >= fixed_cycle_us)
        else $error("fixed cycle ended early");
    chk_peri_none: assert property (
        (ce && start_q && state_q == ST_PERI && !periph_attached)
        |-> tif.value == '0)
        else $error("peripheral budget nonzero with no device");
    chk_fatal_stop: assert property (
        (ce && overrun) |=> cycle_overrun_fatal_error_q
        && fatal_code_q == FATAL_CODE && state_q == ST_HALT ##1
        state_q == ST_HALT)
        else $error("overrun did not stop the sequencer");

    cov_full_cycle: cover property (ce && calc_done && stats_valid_q);
    cov_net_phase: cover property (ce && state_q == ST_NET);
    cov_fixed_wait: cover property (state_q == ST_CALC && !fixed_ok);
    cov_fatal: cover property (ce && overrun);
endmodule // pss_scan_seq

// [core/pss_pkg.sv]
// shared constants, types and states of the scan-cycle sequencer
package pss_pkg;
    localparam int US_W = 24;
    localparam int WORD_W = 16;
    typedef logic [US_W-1:0] pss_us_t;
    typedef logic [WORD_W-1:0] pss_word_t;

    // time base: microsecond tick derived from the 250 MHz clock
    localparam int CLK_MHZ = 250;
    localparam int CYC_PER_US = CLK_MHZ;
    localparam logic [7:0] PRE_LAST = 8'(CYC_PER_US - 1);

    // phase budgets in microseconds, with the peripheral percentage and the link switch codes
    localparam pss_us_t IO_IN_BYTE_US = 24'd70;
    localparam pss_us_t IO_OUT_BYTE_US = 24'd40;
    localparam pss_us_t RIO_MASTER_US = 24'd1300;
    localparam pss_us_t RIO_WORD_US = 24'd200;
    localparam pss_us_t HD_INIT_US = 24'd360;
    localparam pss_us_t HOST_UNIT_US = 24'd8000;
    localparam pss_us_t PERI_SHORT_US = 24'd800;
    localparam pss_us_t PERI_LIMIT_US = 24'd13000;
    localparam logic [31:0] PERI_PCT = 32'd6;
    localparam logic [31:0] PCT_DIV = 32'd100;
    localparam pss_us_t NET_UNIT_US = 24'd1500;
    localparam pss_us_t NET_MAX_US = 24'd10000;
    localparam pss_us_t OVSEE_LARGE_US = 24'd3500;
    localparam pss_us_t OVSEE_NOCLK_US = 24'd2800;
    localparam pss_us_t OVSEE_CLK_US = 24'd3100;
    localparam pss_us_t LINK_512_US = 24'd8900;
    localparam pss_us_t LINK_256_US = 24'd5700;
    localparam pss_us_t LINK_128_US = 24'd3600;
    localparam pss_us_t LINK_64_US = 24'd2800;
    localparam logic [1:0] LINK_SW_512 = 2'h0;
    localparam logic [1:0] LINK_SW_256 = 2'h1;
    localparam logic [1:0] LINK_SW_128 = 2'h2;
    localparam pss_us_t ABS_LIMIT_US = 24'd6500000;
    localparam pss_us_t US_PER_TENTH = 24'd100;

    // running average weight: avg = (7 * avg + cur) / 8
    localparam logic [31:0] AVG_KEEP = 32'h7;
    localparam int AVG_SHIFT = 3;
    localparam logic [7:0] FATAL_CODE = 8'h9F;

    typedef enum logic [3:0] {
        ST_INIT0 = 4'h0,
        ST_INIT1 = 4'h1,
        ST_INIT2 = 4'h2,
        ST_IOREF = 4'h3,
        ST_HOST = 4'h4,
        ST_PERI = 4'h5,
        ST_NET = 4'h6,
        ST_OVSEE = 4'h7,
        ST_PROG = 4'h8,
        ST_CALC = 4'h9,
        ST_HALT = 4'hA
    } pss_state_e;
endpackage

// [core/pss_tmr_if.sv]
// link between the sequencer and its phase timer
`timescale 1ns/1ns
interface pss_tmr_if;
    logic load;
    pss_pkg::pss_us_t value;
    logic tick;
    logic expired;
    modport ctl (output load, output value, output tick, input expired);
    modport tmr (input load, input value, input tick, output expired);
endinterface

// [core/pss_timer.sv]
// microsecond down-counter that times one phase
`timescale 1ns/1ns
module pss_timer (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    pss_tmr_if.tmr t
);
    import pss_pkg::*;

    pss_us_t cnt_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            cnt_q <= '0;
        end else if (ce) begin
            if (t.load) begin
                cnt_q <= t.value;
            end else if (t.tick && cnt_q != '0) begin
                cnt_q <= cnt_q - 24'h1;
            end
        end
    end

    assign t.expired = (cnt_q == '0);

    chk_tmr_load_value: assert property (@(posedge clk) disable iff (reset)
        (ce && t.load) |=> cnt_q == $past(t.value))
        else $error("phase timer did not load its budget");
endmodule // pss_timer

// [sim/pss_io_model.sv]
// far-side model: field input wiring and the program engine
`timescale 1ns/1ns
module pss_io_model #(
    parameter logic [15:0] PIN_PATTERN = 16'h3C5A,
    parameter int RUN_CYCLES = 3
) (
    input wire logic clk,
    input wire logic prog_run,
    output logic prog_done,
    output logic [15:0] in_pins
);
    int cnt_q;

    initial begin
        prog_done = 1'b0;
        in_pins = PIN_PATTERN;
        cnt_q = 0;
    end

    // program engine: one done pulse a few cycles into each program phase
    always @(posedge clk) begin
        if (prog_run !== 1'b1) begin
            cnt_q <= 0;
            prog_done <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 1;
            prog_done <= (cnt_q == RUN_CYCLES);
        end
    end
endmodule // pss_io_model

// [sim/plc_scan_cycle_sequencer_test.sv]
// self-checking bench of the scan-cycle sequencer
`timescale 1ns/1ns
module plc_scan_cycle_sequencer_test;
    import pss_pkg::*;
    // two clocks per microsecond keeps millisecond phases short
    localparam int US_CYC = 2;
    logic clk, reset, ce, larger_cpu, clock_board, periph_attached;
    logic pc_link_en, prog_done, fixed_cycle_en, watchdog_extend_instruction;
    logic [1:0] link_sw;
    logic [7:0] in_bytes, out_bytes, rio_words, fatal_code_q;
    logic [3:0] rio_masters, hd_units, host_units, net_units;
    pss_us_t hd_refresh_us, fixed_cycle_us, wd_limit_us, wd_extend_us;
    pss_us_t avg_cycle_us_q, max_cycle_us_q, min_cycle_us_q;
    logic [15:0] in_pins, out_image, in_image_q, out_pins_q;
    pss_state_e phase_q;
    logic scanning_q, io_service_q, host_service_q, peri_service_q;
    logic net_service_q, prog_run_q, wd_restart_q, bus_check_q;
    logic mem_check_q, rtc_refresh_q, cycle_overrun_fatal_error_q;
    pss_word_t max_cycle_word_q, current_cycle_word_q;
    int fails = 0;
    int n_checks = 0;
    int n_wdr = 0;
    int n_ovs = 0;

    pss_scan_seq #(.IMG_W(16), .CYC_US(US_CYC)) pss_scan_seq_i (
        .clk(clk), .reset(reset), .ce(ce), .larger_cpu(larger_cpu),
        .clock_board(clock_board), .periph_attached(periph_attached),
        .pc_link_en(pc_link_en), .link_sw(link_sw), .in_bytes(in_bytes),
        .out_bytes(out_bytes), .rio_masters(rio_masters),
        .rio_words(rio_words), .hd_units(hd_units),
        .hd_refresh_us(hd_refresh_us), .host_units(host_units),
        .net_units(net_units), .prog_done(prog_done),
        .fixed_cycle_en(fixed_cycle_en), .fixed_cycle_us(fixed_cycle_us),
        .wd_limit_us(wd_limit_us),
        .watchdog_extend_instruction(watchdog_extend_instruction),
        .wd_extend_us(wd_extend_us), .in_pins(in_pins),
        .out_image(out_image), .phase_q(phase_q), .scanning_q(scanning_q),
        .in_image_q(in_image_q), .out_pins_q(out_pins_q),
        .io_service_q(io_service_q), .host_service_q(host_service_q),
        .peri_service_q(peri_service_q), .net_service_q(net_service_q),
        .prog_run_q(prog_run_q), .wd_restart_q(wd_restart_q),
        .bus_check_q(bus_check_q), .mem_check_q(mem_check_q),
        .rtc_refresh_q(rtc_refresh_q), .max_cycle_word_q(max_cycle_word_q),
        .current_cycle_word_q(current_cycle_word_q),
        .avg_cycle_us_q(avg_cycle_us_q), .max_cycle_us_q(max_cycle_us_q),
        .min_cycle_us_q(min_cycle_us_q),
        .cycle_overrun_fatal_error_q(cycle_overrun_fatal_error_q),
        .fatal_code_q(fatal_code_q)
    );

    pss_io_model pss_io_model_i (
        .clk(clk), .prog_run(prog_run_q), .prog_done(prog_done),
        .in_pins(in_pins)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // oversee-entry pulses come together; restarts are counted apart
    always @(posedge clk) begin
        if (wd_restart_q === 1'b1) n_wdr <= n_wdr + 1;
        if (bus_check_q === 1'b1 && mem_check_q === 1'b1
            && rtc_refresh_q === 1'b1) n_ovs <= n_ovs + 1;
    end

    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    task automatic check(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1) begin
            fails++;
            $display("Error %0t: %s", $time, msg);
        end
    endtask

    task automatic do_reset();
        @(posedge clk);
        reset <= 1'b1;
        repeat (12) @(posedge clk);
        #1;
        check(phase_q === ST_INIT0, "reset state");
        check(scanning_q === 1'b0, "reset scan");
        @(posedge clk);
        reset <= 1'b0;
        #1;
        n_wdr = 0;
        n_ovs = 0;
    endtask

    task automatic stay(input pss_state_e st, input int lim, output int n);
        n = 0;
        while (phase_q === st && n < lim) begin
            tick();
            n++;
        end
    endtask

    task automatic skip_init();
        int n;
        stay(ST_INIT0, 4, n);
        stay(ST_INIT1, 2, n);
        stay(ST_INIT2, 2, n);
    endtask

    // a phase of b us lasts (b-1)*US_CYC+3 to b*US_CYC+2 cycles
    task automatic phase_len(input pss_state_e st, input int b,
                             input string msg);
        int n;
        stay(st, b * US_CYC + 10, n);
        check(n >= (b - 1) * US_CYC + 3 && n <= b * US_CYC + 2, msg);
    endtask

    task automatic test_init();
        int n;
        do_reset();
        stay(ST_INIT0, 4, n);
        check(phase_q === ST_INIT1, "first init step");
        tick();
        check(phase_q === ST_INIT2, "second init step");
        tick();
        check(phase_q === ST_IOREF, "scan starts");
        tick();
        check(io_service_q === 1'b1, "io phase");
        check(scanning_q === 1'b1, "scanning");
        check(in_image_q === 16'h3C5A, "inputs latched");
        check(out_pins_q === 16'hA5C3, "outputs driven");
    endtask

    task automatic test_overrun();
        int n;
        for (int big = 0; big < 2; big++) begin
            @(posedge clk);
            larger_cpu <= big[0];
            wd_limit_us <= 24'h000005;
            do_reset();
            skip_init();
            stay(ST_IOREF, 10, n);
            check(phase_q === ST_HOST, "host after io");
            check(host_service_q === 1'b1, "host level");
            stay(ST_HOST, 10, n);
            check(phase_q === ST_PERI, "peripheral after host");
            check(peri_service_q === 1'b1, "peripheral level");
            stay(ST_PERI, 10, n);
            check(n == 2, "no device, empty peripheral phase");
            check(phase_q === (big[0] ? ST_NET : ST_OVSEE), "net");
            check(net_service_q === big[0], "net level");
            stay(phase_q, 2000, n);
            check(phase_q === ST_HALT, "halt");
            check(fatal_code_q === FATAL_CODE, "fatal code");
            check(cycle_overrun_fatal_error_q === 1'b1, "fatal flag");
            check(n_ovs == ((big != 0) ? 0 : 1), "oversee pulses");
            repeat (20) tick();
            check(phase_q === ST_HALT, "stays");
            check(scanning_q === 1'b0, "not scanning");
        end
    endtask

    task automatic test_io_budget();
        int b [4] = '{110, 1500, 370, 2800};
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            larger_cpu <= 1'b0;
            wd_limit_us <= 24'h0F4240;
            in_bytes <= (i == 0) ? 8'h01 : 8'h00;
            out_bytes <= (i == 0) ? 8'h01 : 8'h00;
            rio_masters <= (i == 1) ? 4'h1 : 4'h0;
            rio_words <= (i == 1) ? 8'h01 : 8'h00;
            hd_units <= (i == 2) ? 4'h1 : 4'h0;
            hd_refresh_us <= 24'h00000A;
            pc_link_en <= (i == 3);
            link_sw <= 2'h3;
            do_reset();
            skip_init();
            phase_len(ST_IOREF, b[i], "io len");
        end
    endtask

    task automatic test_host_net();
        @(posedge clk);
        larger_cpu <= 1'b1;
        periph_attached <= 1'b1;
        pc_link_en <= 1'b0;
        host_units <= 4'h1;
        net_units <= 4'h1;
        do_reset();
        skip_init();
        phase_len(ST_IOREF, 0, "io len");
        phase_len(ST_HOST, 8000, "host len");
        phase_len(ST_PERI, 800, "peripheral len");
        phase_len(ST_NET, 11500, "network len");
        phase_len(ST_OVSEE, 3500, "large oversee len");
    endtask

    task automatic test_full_cycle();
        int n;
        @(posedge clk);
        {in_bytes, out_bytes, rio_words} <= 24'h000000;
        {hd_units, host_units, net_units} <= 12'h000;
        {larger_cpu, periph_attached, pc_link_en} <= 3'h0;
        fixed_cycle_en <= 1'b1;
        fixed_cycle_us <= 24'h000001;
        do_reset();
        skip_init();
        stay(ST_IOREF, 10, n);
        stay(ST_HOST, 10, n);
        stay(ST_PERI, 10, n);
        check(phase_q === ST_OVSEE, "oversee entered");
        phase_len(ST_OVSEE, 2800, "oversee length");
        check(phase_q === ST_PROG, "program after oversee");
        stay(ST_PROG, 20, n);
        check(phase_q === ST_CALC, "calculation after program");
        stay(ST_CALC, 20, n);
        check(phase_q === ST_IOREF, "next cycle");
        tick();
        tick();
        check(current_cycle_word_q === 16'h001C, "current word");
        check(max_cycle_word_q === 16'h001C, "max word");
        check(min_cycle_us_q === max_cycle_us_q
              && avg_cycle_us_q === max_cycle_us_q, "first stats");
        check(max_cycle_us_q >= 24'd2800
              && max_cycle_us_q <= 24'd2810, "cycle time");
        check(n_wdr == 2 && n_ovs == 1, "watchdog restarts");
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        reset = 1'b1;
        ce = 1'b1;
        {larger_cpu, clock_board, periph_attached, pc_link_en} = 4'h0;
        {fixed_cycle_en, watchdog_extend_instruction} = 2'h0;
        link_sw = 2'h0;
        {in_bytes, out_bytes, rio_words} = 24'h000000;
        {rio_masters, hd_units, host_units, net_units} = 16'h0000;
        hd_refresh_us = 24'h000000;
        fixed_cycle_us = 24'h000000;
        wd_limit_us = 24'h0F4240;
        wd_extend_us = 24'h000000;
        out_image = 16'hA5C3;
        test_init();
        test_overrun();
        test_io_budget();
        test_host_net();
        test_full_cycle();
        end_of_test();
    end

    // a whole run is about 250 us of simulated time
    initial begin
        #400000;
        fails++;
        $display("Error %0t: run did not finish in time", $time);
        end_of_test();
    end
endmodule // plc_scan_cycle_sequencer_test
